// >>> bench/idp_host_model.sv
// two-wire bus host: register writes and reads with repeated start
// assumes sda is a wired-and with a pull-up made in the testbench
`timescale 1ns/1ps
`default_nettype none
module idp_host_model (
  // clock
  input wire logic clk,
  // bus
  output logic scl,
  output logic sdaLow,
  input wire logic sda
);
  localparam logic [7:0] ADR = {idp_pkg::DEV_ADDR_DEFAULT, 1'b0};
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  // six cycles a phase, above the four the slave needs
  task automatic tick;
    repeat (6) @(posedge clk);
    #1;
  endtask : tick
  task automatic start;
    sdaLow = 1'b0;
    scl = 1'b1;
    tick();
    sdaLow = 1'b1;
    tick();
    scl = 1'b0;
    tick();
  endtask : start
  task automatic stop;
    sdaLow = 1'b1;
    tick();
    scl = 1'b1;
    tick();
    sdaLow = 1'b0;
    tick();
  endtask : stop
  // sda moves a whole phase after scl falls, never beside it
  task automatic bitIo(input logic b, output logic s);
    sdaLow = !b;
    tick();
    scl = 1'b1;
    tick();
    s = sda;
    scl = 1'b0;
    tick();
  endtask : bitIo
  // ninth bit released: slave ack on writes, host nack on reads
  task automatic byteIo(input logic [7:0] tx, output logic [7:0] rx,
      output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitIo(tx[i], rx[i]);
    bitIo(1'b1, a);
    ack = !a;
  endtask : byteIo
  // interface changes go through control register writes only
  task automatic wr(input logic [7:0] p, input logic [7:0] d,
      output logic ok);
    logic [7:0] r;
    logic a0, a1, a2;
    start();
    byteIo(ADR, r, a0);
    byteIo(p, r, a1);
    byteIo(d, r, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask : wr
  task automatic rd(input logic [7:0] p, output logic [7:0] d,
      output logic ok);
    logic [7:0] r;
    logic a0, a1, a2, a3;
    start();
    byteIo(ADR, r, a0);
    byteIo(p, r, a1);
    start();
    byteIo(ADR | 8'h01, r, a2);
    byteIo(8'hFF, d, a3);
    stop();
    ok = a0 & a1 & a2;
  endtask : rd
endmodule : idp_host_model
`default_nettype wire

// >>> bench/idp_power_select_sva.sv
// port assertions for the interface detect and power select block
// assumes it is bound onto every instance of idp_power_select
`timescale 1ns/1ps
`default_nettype none
module idp_power_select_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // bus pin and results
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic activeAnalog,
  input wire logic activeDigital,
  // power enables
  input wire logic pwrSerialBus,
  input wire logic pwrAnalogDetect,
  input wire logic pwrLinkClkDetect,
  input wire logic pwrEmbeddedGreenSync,
  input wire logic pwrBandGap,
  input wire logic pwrAnalogCore,
  input wire logic pwrDigitalCore,
  input wire logic pwrRedOut,
  input wire logic pwrGreenOut,
  input wire logic pwrBlueOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_bus_powered: assert property (pwrSerialBus)
    else $error("serial bus power dropped");
  a_one_active: assert property (!(activeAnalog && activeDigital))
    else $error("both interfaces active");
  // every mode but power-down keeps green sync on, so its loss marks off
  a_off_dark: assert property (!pwrEmbeddedGreenSync |->
    !(pwrAnalogDetect || pwrLinkClkDetect || pwrBandGap || pwrAnalogCore
    || pwrDigitalCore || pwrRedOut || pwrGreenOut || pwrBlueOut))
    else $error("power-down left a block on");
  a_idle_dark: assert property (!activeAnalog && !activeDigital |=>
    !(pwrRedOut || pwrGreenOut || pwrBlueOut || pwrAnalogCore))
    else $error("outputs on with no interface");
  a_digital_power: assert property (activeDigital |=> pwrRedOut &&
    pwrGreenOut && pwrBlueOut && pwrBandGap && pwrEmbeddedGreenSync &&
    pwrAnalogDetect && pwrLinkClkDetect && pwrDigitalCore)
    else $error("digital mode power set wrong");
  a_digital_no_adc: assert property (activeDigital |=> !pwrAnalogCore)
    else $error("analog core on in digital mode");
  a_analog_power: assert property (activeAnalog |=> pwrRedOut &&
    pwrGreenOut && pwrAnalogCore && pwrAnalogDetect && pwrLinkClkDetect &&
    pwrBandGap && pwrEmbeddedGreenSync)
    else $error("analog mode power set wrong");
  a_sda_drain: assert property (sdaOe |-> !sdaOut)
    else $error("sda driven high");
endmodule : idp_power_select_sva
bind idp_power_select idp_power_select_sva u_sva (.clk, .rst_n, .sdaOut,
  .sdaOe, .activeAnalog, .activeDigital, .pwrSerialBus, .pwrAnalogDetect,
  .pwrLinkClkDetect, .pwrEmbeddedGreenSync, .pwrBandGap, .pwrAnalogCore,
  .pwrDigitalCore, .pwrRedOut, .pwrGreenOut, .pwrBlueOut);
`default_nettype wire

// >>> bench/testbench.sv
// self-checking bench for the interface detect and power select block
// assumes the host model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [11:0] ALL = 12'hFFF;
  localparam logic [11:0] MS = 12'hFFF;
  localparam logic [11:0] SEEK = 12'h3C0;
  localparam logic [11:0] AN = 12'hBF7;
  localparam logic [11:0] AN2 = 12'hBF6;
  localparam logic [11:0] DIG = 12'h7EF;
  localparam logic [11:0] OFF = 12'h200;
  localparam logic [7:0] RO = idp_pkg::REG_OVERRIDE;
  localparam logic [7:0] RP = idp_pkg::REG_POWER;
  localparam logic [7:0] RS = idp_pkg::REG_STATUS;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] ph = 4'h0;
  // pin enables: hsync, vsync, green sync, link clock, data enable
  logic [4:0] en = 5'h00;
  int nMismatch = 0;
  int cmpCount = 0;
  int cyc = 0;
  wire logic scl, hostLow, sdaOut, sdaOe, aA, aD, lock;
  wire logic [9:0] pw;
  wire logic sda = !(hostLow || sdaOe);
  idp_power_select #(.DETECT_CYCLES(64)) dut (.clk(clk), .rst_n(rst_n),
    .sclIn(scl), .sdaIn(sda), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .hsyncPin(en[4] & ph[3]), .vsyncPin(en[3] & ph[3]),
    .embeddedGreenSyncPin(en[2] & ph[3]), .linkClkPin(en[1] & ph[3]),
    .dataEnablePin(en[0] & ph[3]), .activeAnalog(aA), .activeDigital(aD),
    .digitalLocked(lock), .pwrSerialBus(pw[9]), .pwrAnalogDetect(pw[8]),
    .pwrLinkClkDetect(pw[7]), .pwrEmbeddedGreenSync(pw[6]),
    .pwrBandGap(pw[5]), .pwrAnalogCore(pw[4]), .pwrDigitalCore(pw[3]),
    .pwrRedOut(pw[2]), .pwrGreenOut(pw[1]), .pwrBlueOut(pw[0]));
  idp_host_model host (.clk(clk), .scl(scl), .sdaLow(hostLow), .sda(sda));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    #1;
    ph <= ph + 4'h1;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 50000) begin
      nMismatch++;
      finishTest();
    end
  end
  task automatic finishTest;
    $display("checks %0d mismatches %0d", cmpCount, nMismatch);
    if (nMismatch == 0 && cmpCount > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : finishTest
  task automatic chk(input string nm, input logic [11:0] s, e);
    cmpCount++;
    if (s !== e) begin
      nMismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle
  // seek keeps serial bus, both clock detectors and green sync only
  task automatic mode(input string nm, input logic [11:0] m, e);
    idle(8);
    chk(nm, {aA, aD, pw} & m, e);
  endtask : mode
  task automatic wr(input logic [7:0] p, d);
    logic ok;
    host.wr(p, d, ok);
    chk("write ack", {11'h0, ok}, 12'h1);
  endtask : wr
  task automatic rdc(input string nm, input logic [7:0] p, e);
    logic [7:0] d;
    logic ok;
    host.rd(p, d, ok);
    chk(nm, {3'h0, ok, d}, {4'h1, e});
  endtask : rdc
  task automatic tReset;
    mode("seek", MS, SEEK);
    rdc("override reg", RO, idp_pkg::OVERRIDE_RESET);
    rdc("power reg", RP, idp_pkg::POWER_RESET);
    rdc("unmapped", 8'h20, idp_pkg::READ_EMPTY);
    rdc("status idle", RS, 8'h00);
    $display("test reset done");
  endtask : tReset
  task automatic tSync;
    logic [4:0] pin [3] = '{5'h10, 5'h08, 5'h04};
    logic [7:0] flag [3] = '{8'h80, 8'h20, 8'h40};
    wr(RO, 8'h02);
    for (int i = 0; i < 3; i++) begin
      en = pin[i];
      idle(40);
      rdc("sync flag", RS, flag[i]);
      mode("analog only", ALL, AN);
      en = 5'h00;
      idle(80);
      rdc("sync lost", RS, 8'h00);
      mode("seek again", MS, SEEK);
    end
    $display("test sync done");
  endtask : tSync
  task automatic tDigital;
    wr(RO, 8'h00);
    en = 5'h02;
    idle(40);
    rdc("link flag", RS, 8'h10);
    mode("digital only", ALL, DIG);
    en = 5'h03;
    idle(300);
    chk("early lock", {11'h0, lock}, 12'h0);
    idle(300);
    chk("locked", {11'h0, lock}, 12'h1);
    en = 5'h13;
    idle(40);
    rdc("both flags", RS, 8'h98);
    mode("both analog first", 12'hFF7, AN);
    wr(RO, 8'h02);
    mode("both digital first", ALL, DIG);
    en = 5'h00;
    idle(80);
    rdc("link lost", RS, 8'h00);
    chk("lock lost", {11'h0, lock}, 12'h0);
    mode("seek", MS, SEEK);
    $display("test digital done");
  endtask : tDigital
  task automatic tOverride;
    wr(RO, 8'h04);
    mode("forced analog", ALL, AN);
    wr(RP, 8'h06);
    mode("analog 422", ALL, AN2);
    wr(RO, 8'h06);
    mode("forced digital", ALL, DIG);
    wr(RP, 8'h04);
    mode("power down", ALL, OFF);
    wr(RS, 8'hFF);
    rdc("status read only", RS, 8'h00);
    rdc("power reg", RP, 8'h04);
    wr(RP, idp_pkg::POWER_RESET);
    wr(RO, 8'h00);
    mode("restored", MS, SEEK);
    $display("test override done");
  endtask : tOverride
  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    idle(8);
    tReset();
    tSync();
    tDigital();
    tOverride();
    finishTest();
  end
endmodule : testbench
`default_nettype wire

// >>> src/idp_activity_det.sv
// activity detector: synchronises one pin and watches it for edges
// assumes the pin is asynchronous to clk and toggles slower than clk/4
`timescale 1ns/1ps
`default_nettype none

module idp_activity_det #(
  parameter int TIMEOUT = idp_pkg::DETECT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstN,
  // pin
  input wire logic pin,
  // results
  output logic level,
  output logic rise,
  output logic active
);

  localparam int CW = $clog2(TIMEOUT + 1);
  localparam logic [CW-1:0] RELOAD = CW'(TIMEOUT);

  logic s1_r, s2_r, s3_r, filt_r, prev_r, active_r;
  logic [CW-1:0] cnt_r;
  wire agree = (s2_r == s3_r);
  wire anyEdge = (filt_r != prev_r);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      filt_r <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) filt_r <= s3_r;
      prev_r <= filt_r;
    end
  end

  // a quiet pin drops the flag after at most TIMEOUT cycles
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_r <= '0;
      active_r <= 1'b0;
    end else if (anyEdge) begin
      cnt_r <= RELOAD;
      active_r <= 1'b1;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
      active_r <= (cnt_r != CW'(1));
    end else begin
      active_r <= 1'b0;
    end
  end

  assign level = filt_r;
  assign rise = filt_r & ~prev_r;
  assign active = active_r;

endmodule : idp_activity_det

`default_nettype wire

// >>> src/idp_pkg.sv
// shared constants for the interface detect and power select block
// assumes a 200 MHz system clock and a two-wire serial host outside
package idp_pkg;

  // register offsets on the two-wire bus
  localparam logic [7:0] REG_OVERRIDE = 8'h0F;
  localparam logic [7:0] REG_POWER = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h15;

  // reset values, and the value read back from unmapped offsets
  localparam logic [7:0] OVERRIDE_RESET = 8'h00;
  localparam logic [7:0] POWER_RESET = 8'h02;
  localparam logic [7:0] READ_EMPTY = 8'h00;

  // field positions
  localparam int OVR_ENABLE_BIT = 2;
  localparam int OVR_CHOICE_BIT = 1;
  localparam int PWR_ENABLE_BIT = 1;
  localparam int PWR_FMT422_BIT = 2;
  localparam int ST_HSYNC_BIT = 7;
  localparam int ST_SOG_BIT = 6;
  localparam int ST_VSYNC_BIT = 5;
  localparam int ST_LINKCLK_BIT = 4;
  localparam int ST_DELOCK_BIT = 3;

  // serial bus framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h4C;

  // timing
  localparam int CLK_MHZ = 200;
  localparam int DETECT_TIME_US = 100000;
  localparam int DETECT_CYCLES = DETECT_TIME_US * CLK_MHZ;
  localparam int DE_LOCK_COUNT = 32;

  // power modes
  typedef enum logic [3:0] {
    MODE_OFF = 4'b0001,
    MODE_SEEK = 4'b0010,
    MODE_ANALOG = 4'b0100,
    MODE_DIGITAL = 4'b1000
  } idp_mode_t;

  // serial slave states
  typedef enum logic [8:0] {
    SS_IDLE = 9'b000000001,
    SS_ADDR = 9'b000000010,
    SS_ACKA = 9'b000000100,
    SS_PTR = 9'b000001000,
    SS_ACKP = 9'b000010000,
    SS_WDATA = 9'b000100000,
    SS_ACKW = 9'b001000000,
    SS_RDATA = 9'b010000000,
    SS_RACK = 9'b100000000
  } idp_ser_t;

endpackage : idp_pkg

// >>> src/idp_power_select.sv
// interface detect and power select with its two-wire register slave
// assumes scl and sda arrive from an open-drain bus, asynchronous to clk
`timescale 1ns/1ps
`default_nettype none

module idp_power_select #(
  parameter int DETECT_CYCLES = idp_pkg::DETECT_CYCLES,
  parameter logic [6:0] DEV_ADDR = idp_pkg::DEV_ADDR_DEFAULT,
  parameter int DE_LOCK = idp_pkg::DE_LOCK_COUNT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // two-wire serial bus
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // monitored pins
  input wire logic hsyncPin,
  input wire logic vsyncPin,
  input wire logic embeddedGreenSyncPin,
  input wire logic linkClkPin,
  input wire logic dataEnablePin,
  // selection result
  output logic activeAnalog,
  output logic activeDigital,
  output logic digitalLocked,
  // power enables
  output logic pwrSerialBus,
  output logic pwrAnalogDetect,
  output logic pwrLinkClkDetect,
  output logic pwrEmbeddedGreenSync,
  output logic pwrBandGap,
  output logic pwrAnalogCore,
  output logic pwrDigitalCore,
  output logic pwrRedOut,
  output logic pwrGreenOut,
  output logic pwrBlueOut
);

  localparam int DW = $clog2(DE_LOCK + 1);
  localparam logic [DW-1:0] DE_LAST = DW'(DE_LOCK - 1);

  // reset release
  logic rsA_r, rsB_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsA_r <= 1'b0;
      rsB_r <= 1'b0;
    end else begin
      rsA_r <= 1'b1;
      rsB_r <= rsA_r;
    end
  end
  wire rstN = rsB_r;

  // activity detectors
  logic hsAct, vsAct, sogAct, lclkAct, deRise;
  logic sclLvl, sclRise, sdaLvl, sdaRise;

  idp_activity_det #(.TIMEOUT(DETECT_CYCLES)) uHs (
    .clk(clk), .rstN(rstN), .pin(hsyncPin),
    .level(), .rise(), .active(hsAct));
  idp_activity_det #(.TIMEOUT(DETECT_CYCLES)) uVs (
    .clk(clk), .rstN(rstN), .pin(vsyncPin),
    .level(), .rise(), .active(vsAct));
  idp_activity_det #(.TIMEOUT(DETECT_CYCLES)) uSog (
    .clk(clk), .rstN(rstN), .pin(embeddedGreenSyncPin),
    .level(), .rise(), .active(sogAct));
  // always running, independent of the digital power enable
  idp_activity_det #(.TIMEOUT(DETECT_CYCLES)) uLclk (
    .clk(clk), .rstN(rstN), .pin(linkClkPin),
    .level(), .rise(), .active(lclkAct));
  idp_activity_det #(.TIMEOUT(DETECT_CYCLES)) uDe (
    .clk(clk), .rstN(rstN), .pin(dataEnablePin),
    .level(), .rise(deRise), .active());
  // bus pins reuse the synchroniser; their timeout is irrelevant
  idp_activity_det #(.TIMEOUT(1)) uScl (
    .clk(clk), .rstN(rstN), .pin(sclIn),
    .level(sclLvl), .rise(sclRise), .active());
  idp_activity_det #(.TIMEOUT(1)) uSda (
    .clk(clk), .rstN(rstN), .pin(sdaIn),
    .level(sdaLvl), .rise(sdaRise), .active());

  // control registers
  logic [7:0] ovrReg_r, pwrReg_r;
  wire ovrEnable = ovrReg_r[idp_pkg::OVR_ENABLE_BIT];
  wire ovrChoice = ovrReg_r[idp_pkg::OVR_CHOICE_BIT];
  wire powerEnable = pwrReg_r[idp_pkg::PWR_ENABLE_BIT];
  wire fmt422 = pwrReg_r[idp_pkg::PWR_FMT422_BIT];

  // status and detection
  logic deLock_r;
  logic [DW-1:0] deCnt_r;
  wire [7:0] statusWord = {hsAct, sogAct, vsAct, lclkAct, deLock_r,
                           3'b000};
  wire analogDet = statusWord[idp_pkg::ST_HSYNC_BIT]
                 | statusWord[idp_pkg::ST_SOG_BIT]
                 | statusWord[idp_pkg::ST_VSYNC_BIT];
  wire digitalDet = statusWord[idp_pkg::ST_LINKCLK_BIT];

  // mode resolution, evaluated every cycle
  idp_pkg::idp_mode_t mode_nxt, mode_r;
  always_comb begin
    if (!powerEnable)
      mode_nxt = idp_pkg::MODE_OFF;
    else if (ovrEnable)
      mode_nxt = ovrChoice ? idp_pkg::MODE_DIGITAL
                           : idp_pkg::MODE_ANALOG;
    else if (analogDet && digitalDet)
      mode_nxt = ovrChoice ? idp_pkg::MODE_DIGITAL
                           : idp_pkg::MODE_ANALOG;
    else if (digitalDet)
      mode_nxt = idp_pkg::MODE_DIGITAL;
    else if (analogDet)
      mode_nxt = idp_pkg::MODE_ANALOG;
    else
      mode_nxt = idp_pkg::MODE_SEEK;
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) mode_r <= idp_pkg::MODE_SEEK;
    else mode_r <= mode_nxt;
  end

  // data-enable qualification once the link clock is present
  wire digPowered = (mode_r == idp_pkg::MODE_DIGITAL)
                  || (lclkAct && mode_r != idp_pkg::MODE_OFF);
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      deCnt_r <= '0;
      deLock_r <= 1'b0;
    end else if (!digPowered) begin
      deCnt_r <= '0;
      deLock_r <= 1'b0;
    end else if (deRise && !deLock_r) begin
      deCnt_r <= deCnt_r + 1'b1;
      deLock_r <= (deCnt_r == DE_LAST);
    end
  end

  // power enables per mode
  logic [11:0] pwr_nxt, pwr_r;
  always_comb begin
    case (mode_r)
      idp_pkg::MODE_OFF: pwr_nxt = 12'h000;
      idp_pkg::MODE_SEEK: pwr_nxt = 12'h007;
      idp_pkg::MODE_DIGITAL: pwr_nxt = 12'h0FF;
      idp_pkg::MODE_ANALOG:
        pwr_nxt = fmt422 ? 12'h13F : 12'h1BF;
      default: pwr_nxt = 12'h000;
    endcase
    // the link clock detector powers the digital core ahead of selection
    if (mode_r != idp_pkg::MODE_OFF && lclkAct)
      pwr_nxt[6] = 1'b1;
  end
  // bit map: 0 analog detect, 1 link clock detect, 2 green sync,
  // 3 band gap, 4 red, 5 green, 6 digital core, 7 blue, 8 analog core,
  // 9 also drives analog detect but no mode sets it, 10 and 11 spare
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) pwr_r <= 12'h000;
    else pwr_r <= pwr_nxt;
  end

  // two-wire slave
  idp_pkg::idp_ser_t ss_r;
  logic [3:0] bitCnt_r;
  logic [7:0] sh_r, tx_r, ptr_r;
  logic reading_r, rackNak_r, sclPrev_r;
  logic sdaPrev_r;
  wire sclFall = sclPrev_r & ~sclLvl;
  wire sdaFallSeen = sdaPrev_r & ~sdaLvl;
  wire startCond = sclLvl && sclPrev_r && !sdaLvl && !sdaRise
                 && sdaFallSeen;
  wire stopCond = sclLvl && sclPrev_r && sdaRise;
  wire byteDone = (bitCnt_r == idp_pkg::BITS_PER_BYTE);
  wire addrHit = (sh_r[7:1] == DEV_ADDR);

  function automatic logic [7:0] readMux(input logic [7:0] a,
      input logic [7:0] o, input logic [7:0] p, input logic [7:0] s);
    if (a == idp_pkg::REG_OVERRIDE) return o;
    else if (a == idp_pkg::REG_POWER) return p;
    else if (a == idp_pkg::REG_STATUS) return s;
    else return idp_pkg::READ_EMPTY;
  endfunction : readMux

  wire [7:0] readNow = readMux(ptr_r, ovrReg_r, pwrReg_r, statusWord);
  wire inRx = (ss_r == idp_pkg::SS_ADDR) || (ss_r == idp_pkg::SS_PTR)
            || (ss_r == idp_pkg::SS_WDATA);
  wire wrStrobe = sclFall && byteDone && (ss_r == idp_pkg::SS_WDATA);

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sclPrev_r <= 1'b0;
      sdaPrev_r <= 1'b0;
    end else begin
      sclPrev_r <= sclLvl;
      sdaPrev_r <= sdaLvl;
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ss_r <= idp_pkg::SS_IDLE;
      bitCnt_r <= '0;
      sh_r <= '0;
      tx_r <= '0;
      ptr_r <= '0;
      reading_r <= 1'b0;
      rackNak_r <= 1'b0;
    end else if (startCond) begin
      ss_r <= idp_pkg::SS_ADDR;
      bitCnt_r <= '0;
    end else if (stopCond) begin
      ss_r <= idp_pkg::SS_IDLE;
    end else if (sclRise) begin
      if (inRx) sh_r <= {sh_r[6:0], sdaLvl};
      if (inRx || ss_r == idp_pkg::SS_RDATA) bitCnt_r <= bitCnt_r + 1'b1;
      if (ss_r == idp_pkg::SS_RACK) rackNak_r <= sdaLvl;
    end else if (sclFall) begin
      case (ss_r)
        idp_pkg::SS_ADDR: if (byteDone) begin
          ss_r <= addrHit ? idp_pkg::SS_ACKA : idp_pkg::SS_IDLE;
          reading_r <= sh_r[0];
        end
        idp_pkg::SS_ACKA: begin
          bitCnt_r <= '0;
          tx_r <= readNow;
          ss_r <= reading_r ? idp_pkg::SS_RDATA : idp_pkg::SS_PTR;
        end
        idp_pkg::SS_PTR: if (byteDone) begin
          ptr_r <= sh_r;
          ss_r <= idp_pkg::SS_ACKP;
        end
        idp_pkg::SS_ACKP, idp_pkg::SS_ACKW: begin
          bitCnt_r <= '0;
          ss_r <= idp_pkg::SS_WDATA;
        end
        idp_pkg::SS_WDATA: if (byteDone) begin
          ptr_r <= ptr_r + 8'h01;
          ss_r <= idp_pkg::SS_ACKW;
        end
        idp_pkg::SS_RDATA: begin
          if (byteDone) begin
            ss_r <= idp_pkg::SS_RACK;
            ptr_r <= ptr_r + 8'h01;
          end else begin
            tx_r <= {tx_r[6:0], 1'b0};
          end
        end
        idp_pkg::SS_RACK: begin
          bitCnt_r <= '0;
          tx_r <= readNow;
          ss_r <= rackNak_r ? idp_pkg::SS_IDLE : idp_pkg::SS_RDATA;
        end
        default: ss_r <= idp_pkg::SS_IDLE;
      endcase
    end
  end

  // register writes; the status word has no storage behind it
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      ovrReg_r <= idp_pkg::OVERRIDE_RESET;
      pwrReg_r <= idp_pkg::POWER_RESET;
    end else if (wrStrobe) begin
      if (ptr_r == idp_pkg::REG_OVERRIDE) ovrReg_r <= sh_r;
      if (ptr_r == idp_pkg::REG_POWER) pwrReg_r <= sh_r;
    end
  end

  // open drain: only ever pulls low
  wire ackPhase = (ss_r == idp_pkg::SS_ACKA) || (ss_r == idp_pkg::SS_ACKP)
                || (ss_r == idp_pkg::SS_ACKW);
  assign sdaOut = 1'b0;
  assign sdaOe = ackPhase || (ss_r == idp_pkg::SS_RDATA && !tx_r[7]);

  assign activeAnalog = (mode_r == idp_pkg::MODE_ANALOG);
  assign activeDigital = (mode_r == idp_pkg::MODE_DIGITAL);
  assign digitalLocked = deLock_r;
  assign pwrSerialBus = 1'b1;
  assign pwrAnalogDetect = pwr_r[0] | pwr_r[9];
  assign pwrLinkClkDetect = pwr_r[1];
  assign pwrEmbeddedGreenSync = pwr_r[2];
  assign pwrBandGap = pwr_r[3];
  assign pwrRedOut = pwr_r[4];
  assign pwrGreenOut = pwr_r[5];
  assign pwrDigitalCore = pwr_r[6];
  assign pwrBlueOut = pwr_r[7];
  assign pwrAnalogCore = pwr_r[8];

endmodule : idp_power_select

`default_nettype wire
